// file: rtl/nv_access_pkg.sv
// Constants shared by the processor-side end and the storage-controller end.
// Assumes one 100 MHz clock and an active-low asynchronous reset on both ends.
// Notes on behaviour
// [R1] Control bits 7..4 always read zero.
// [R2] Ready interrupt held while write_strobe reads zero.
// [R3] Write starts only while master_write_arm set.
// [R4] master_write_arm self-clears four cycles after set.
// [R5] Software arms then strobes within four cycles.
// [R6] write_strobe clears after 8448 one-MHz ticks.
// [R7] Setting write_strobe stalls CPU two cycles.
// [R8] read_strobe fetches byte, then self-clears.
// [R9] Setting read_strobe stalls CPU four cycles.
// [R10] Address or data write aborts active write.
// [R11] Keep interrupts off during write sequence.
// [R12] Active write continues through power-down request.
// [R13] Low registers support bit set, clear, test.
// [R14] Software writes zero to reserved bits.
// [R15] Seven-bit address, top bit reads zero.
// [R16] Data register holds write byte, receives read.
// [R17] Active write survives reset.
// [R18] Arm window counts from arming write; restarts.
// [R19] Ignored write_strobe reads zero, no stall.
package nv_access_pkg;
  localparam logic [5:0] CTRL_ADDR = 6'h1C; // Control register offset
  localparam logic [5:0] DATA_ADDR = 6'h1D; // Data register offset
  localparam logic [5:0] ADDR_ADDR = 6'h1E; // Address register offset
  localparam logic [5:0] BIT_IO_TOP = 6'h1F; // Highest bit-accessible offset
  localparam int RD_STROBE_BIT = 0; // read_strobe position
  localparam int WR_STROBE_BIT = 1; // write_strobe position
  localparam int ARM_BIT = 2; // master_write_arm position
  localparam int IRQ_EN_BIT = 3; // ready_irq_enable position
  localparam logic [7:0] CTRL_RESET = 8'h00; // Control reset value
  localparam int CLK_MHZ = 100; // System clock rate
  localparam int ARM_CYCLES = 4; // Arm window in clocks
  localparam logic [2:0] ARM_CNT_LOAD = 3'h4; // Arm window counter load
  localparam int WR_STALL_CYCLES = 2; // Stall after write strobe
  localparam int RD_STALL_CYCLES = 4; // Stall after read strobe
  localparam logic [2:0] WR_STALL_LOAD = 3'h2; // Write stall counter load
  localparam logic [2:0] RD_STALL_LOAD = 3'h4; // Read stall counter load
  localparam int RC_MHZ = 1; // Calibrated RC rate
  localparam int PROG_RC_TICKS = 8448; // Programming period in RC ticks
  localparam int PROG_CYCLES_DEF = PROG_RC_TICKS * (CLK_MHZ / RC_MHZ); // Period in clocks
  // Bus operation codes from the core
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, // Idle
    OP_READ = 3'b001, // Whole-byte read
    OP_WRITE = 3'b010, // Whole-byte write
    OP_SETBIT = 3'b011, // Single-bit set
    OP_CLRBIT = 3'b100, // Single-bit clear
    OP_TESTBIT = 3'b101 // Skip-on-bit test
  } io_op_e;
endpackage : nv_access_pkg

// file: rtl/nv_io_if.sv
// Register access link between the core end and the storage-control end.
// Assumes both ends share clock and rst_n.
interface nv_io_if (
  input wire logic clock, // System clock
  input wire logic rst_n // Active-low reset
);
  import nv_access_pkg::*;
  io_op_e op; // Operation this cycle
  logic [5:0] addr; // I/O offset
  logic [2:0] bit_sel; // Bit for bit operations
  logic [7:0] wdata; // Whole-byte write data
  logic [7:0] rdata; // Read data, registered
  logic bit_value; // Tested bit value, registered
  logic rvalid; // Read or test answer valid
  logic stall; // Core must hold next instruction
  logic ready_irq; // Ready interrupt request
  logic global_irq_en; // Core interrupt enable
  modport core (output op, addr, bit_sel, wdata, global_irq_en,
                input rdata, bit_value, rvalid, stall, ready_irq);
  modport nvm (input op, addr, bit_sel, wdata, global_irq_en,
               output rdata, bit_value, rvalid, stall, ready_irq);
endinterface : nv_io_if

// file: rtl/nv_core_port.sv
// Core end: turns user requests into I/O operations and waits out stalls.
// Assumes the user holds a request until req_done.
module nv_core_port
  import nv_access_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst_n, // Active-low reset
  nv_io_if.core bus, // Link to storage end
  input wire logic req, // Request pending
  input wire logic [2:0] req_op, // Operation code
  input wire logic [5:0] req_addr, // Offset
  input wire logic [2:0] req_bit, // Bit number
  input wire logic [7:0] req_data, // Write data
  input wire logic irq_en, // Global interrupt enable
  output logic req_done, // One-cycle completion
  output logic [7:0] resp_data, // Read result
  output logic resp_bit, // Test result
  output logic irq_seen // Ready interrupt seen
);
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_WAIT = 2'b01, S_DONE = 2'b10} core_state_e;
  core_state_e state_reg, state_next; // Sequencer
  logic [7:0] resp_data_reg, resp_data_next; // Captured data
  logic resp_bit_reg, resp_bit_next; // Captured bit
  logic done_reg, done_next; // Completion pulse
  logic irq_reg; // Registered interrupt
  io_op_e op_reg, op_next; // Issued operation
  logic [5:0] addr_reg, addr_next; // Issued offset
  logic [2:0] bit_reg, bit_next; // Issued bit
  logic [7:0] wdata_reg, wdata_next; // Issued data
  logic ien_reg; // Interrupt enable to link

  assign bus.op = op_reg;
  assign bus.addr = addr_reg;
  assign bus.bit_sel = bit_reg;
  assign bus.wdata = wdata_reg;
  assign bus.global_irq_en = ien_reg; // R11
  assign req_done = done_reg;
  assign resp_data = resp_data_reg;
  assign resp_bit = resp_bit_reg;
  assign irq_seen = irq_reg;

  // Issue one operation, then wait for answer and end of stall
  always_comb begin
    state_next = state_reg;
    op_next = OP_NONE;
    addr_next = addr_reg;
    bit_next = bit_reg;
    wdata_next = wdata_reg;
    resp_data_next = resp_data_reg;
    resp_bit_next = resp_bit_reg;
    done_next = 1'b0;
    case (state_reg)
      S_IDLE: begin
        // Skip the cycle right after done: the user has not yet seen the pulse
        if (req && !bus.stall && !done_reg) begin
          op_next = io_op_e'(req_op);
          addr_next = req_addr;
          bit_next = req_bit;
          wdata_next = (req_addr == CTRL_ADDR) ? {4'h0, req_data[3:0]} : req_data; // R14
          state_next = S_WAIT;
        end
      end
      S_WAIT: begin
        if (bus.rvalid) begin
          resp_data_next = bus.rdata;
          resp_bit_next = bus.bit_value;
        end
        if (!bus.stall) begin
          state_next = S_DONE;
        end
      end
      S_DONE: begin
        // The answer arrives one cycle after the operation, so it lands here
        if (bus.rvalid) begin
          resp_data_next = bus.rdata;
          resp_bit_next = bus.bit_value;
        end
        if (!bus.stall) begin
          done_next = 1'b1; // R7 R9
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Register sequencer state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      op_reg <= OP_NONE;
      addr_reg <= 6'h00;
      bit_reg <= 3'h0;
      wdata_reg <= 8'h00;
      resp_data_reg <= 8'h00;
      resp_bit_reg <= 1'b0;
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
      ien_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      bit_reg <= bit_next;
      wdata_reg <= wdata_next;
      resp_data_reg <= resp_data_next;
      resp_bit_reg <= resp_bit_next;
      done_reg <= done_next;
      irq_reg <= bus.ready_irq;
      ien_reg <= irq_en;
    end
  end
endmodule : nv_core_port

// file: rtl/nv_access_ctrl.sv
// Storage-control end: control, data and address registers, arm window,
// self-timed write, single-step read, stall and ready interrupt.
// Assumes the core drives at most one operation per cycle and honours stall.
// Cell array is modelled as a 128-byte array kept here.
module nv_access_ctrl
  import nv_access_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF // Programming period in clocks
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Active-low reset
  nv_io_if.nvm bus, // Link from core
  input wire logic sleep_req, // Power-down requested
  output logic write_busy, // Programming in progress
  output logic osc_hold // Oscillator must stay on
);
  logic [7:0] cell_mem [0:127]; // Storage cells
  logic [6:0] addr_reg, addr_next; // Address, top bit absent
  logic [7:0] data_reg, data_next; // Data register
  logic irq_en_reg, irq_en_next; // ready_irq_enable
  logic arm_reg, arm_next; // master_write_arm
  logic wr_reg, wr_next; // write_strobe
  logic rd_reg, rd_next; // read_strobe
  logic [2:0] arm_cnt_reg, arm_cnt_next; // Arm window count
  logic [2:0] stall_reg, stall_next; // Stall count
  logic [19:0] prog_cnt_reg, prog_cnt_next; // Programming count, wide enough for the full period
  logic [7:0] rdata_reg, rdata_next; // Read answer
  logic bitv_reg, bitv_next; // Tested bit
  logic rvalid_reg, rvalid_next; // Answer valid
  logic irq_reg, irq_next; // Ready interrupt
  logic hold_reg, hold_next; // Oscillator hold
  logic mem_we; // Commit write to cells
  logic [7:0] cur; // Addressed register value
  logic [7:0] nv; // Modified register value
  logic is_wr; // Operation writes a register
  logic [7:0] ctrl_rd; // Control readback

  assign bus.rdata = rdata_reg;
  assign bus.bit_value = bitv_reg;
  assign bus.rvalid = rvalid_reg;
  assign bus.stall = (stall_reg != 3'h0);
  assign bus.ready_irq = irq_reg;
  assign write_busy = wr_reg;
  assign osc_hold = hold_reg;
  assign ctrl_rd = {4'h0, irq_en_reg, arm_reg, wr_reg, rd_reg}; // R1

  // Register decode, bit operations and all control sequencing
  always_comb begin
    addr_next = addr_reg;
    data_next = data_reg;
    irq_en_next = irq_en_reg;
    arm_next = arm_reg;
    wr_next = wr_reg;
    rd_next = 1'b0; // R8
    arm_cnt_next = arm_cnt_reg;
    stall_next = (stall_reg != 3'h0) ? stall_reg - 3'h1 : 3'h0;
    prog_cnt_next = prog_cnt_reg;
    rdata_next = rdata_reg;
    bitv_next = bitv_reg;
    rvalid_next = 1'b0;
    mem_we = 1'b0;
    is_wr = 1'b0;
    nv = 8'h00;
    // Current register value, unmapped offsets read zero
    case (bus.addr)
      CTRL_ADDR: cur = ctrl_rd;
      DATA_ADDR: cur = data_reg;
      ADDR_ADDR: cur = {1'b0, addr_reg}; // R15
      default: cur = 8'h00;
    endcase
    // Arm window countdown
    if (arm_cnt_reg != 3'h0) begin
      arm_cnt_next = arm_cnt_reg - 3'h1;
      if (arm_cnt_reg == 3'h1) begin
        arm_next = 1'b0; // R4
      end
    end
    // Programming count, up from zero to one below the period
    if (wr_reg) begin
      if (prog_cnt_reg == 20'(PROG_CYCLES - 1)) begin
        wr_next = 1'b0; // R6
        mem_we = 1'b1; // R12 R17
      end else begin
        prog_cnt_next = prog_cnt_reg + 20'h00001;
      end
    end
    // Operation decode; bit ops only at or below the bit-access limit
    case (bus.op)
      OP_READ: begin
        rdata_next = cur;
        rvalid_next = 1'b1;
      end
      OP_WRITE: begin
        nv = bus.wdata;
        is_wr = 1'b1;
      end
      OP_SETBIT: begin
        nv = cur | (8'h01 << bus.bit_sel);
        is_wr = (bus.addr <= BIT_IO_TOP); // R13
      end
      OP_CLRBIT: begin
        nv = cur & ~(8'h01 << bus.bit_sel);
        is_wr = (bus.addr <= BIT_IO_TOP); // R13
      end
      OP_TESTBIT: begin
        bitv_next = cur[bus.bit_sel]; // R13
        rvalid_next = (bus.addr <= BIT_IO_TOP);
      end
      default: begin
      end
    endcase
    if (is_wr) begin
      case (bus.addr)
        CTRL_ADDR: begin
          irq_en_next = nv[IRQ_EN_BIT];
          if (nv[ARM_BIT] && !arm_reg) begin
            arm_next = 1'b1;
            arm_cnt_next = ARM_CNT_LOAD; // R18
          end else if (nv[ARM_BIT] && (bus.op == OP_WRITE || bus.bit_sel == 3'(ARM_BIT))) begin
            // Only a real new setting restarts; setting another bit does not
            arm_cnt_next = ARM_CNT_LOAD; // R18
          end
          if (nv[WR_STROBE_BIT] && !wr_reg && arm_reg) begin
            wr_next = 1'b1; // R3
            prog_cnt_next = 20'h00000;
            stall_next = WR_STALL_LOAD; // R7
          end
          // Without arm the strobe stays zero and no stall: R19
          if (nv[RD_STROBE_BIT] && !wr_reg) begin
            rd_next = 1'b1;
            data_next = cell_mem[addr_reg]; // R8 R16
            stall_next = RD_STALL_LOAD; // R9
          end
        end
        DATA_ADDR: begin
          data_next = nv; // R16
          if (wr_reg) begin
            wr_next = 1'b0; // R10
          end
        end
        ADDR_ADDR: begin
          addr_next = nv[6:0]; // R15
          if (wr_reg) begin
            wr_next = 1'b0; // R10
          end
        end
        default: begin
        end
      endcase
    end
    irq_next = irq_en_reg && bus.global_irq_en && !wr_reg; // R2
    hold_next = sleep_req && wr_reg; // R12
  end

  // Register control state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= CTRL_RESET[IRQ_EN_BIT];
      arm_reg <= CTRL_RESET[ARM_BIT];
      rd_reg <= CTRL_RESET[RD_STROBE_BIT];
      arm_cnt_reg <= 3'h0;
      stall_reg <= 3'h0;
      rdata_reg <= 8'h00;
      bitv_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      irq_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      irq_en_reg <= irq_en_next;
      arm_reg <= arm_next;
      rd_reg <= rd_next;
      arm_cnt_reg <= arm_cnt_next;
      stall_reg <= stall_next;
      rdata_reg <= rdata_next;
      bitv_reg <= bitv_next;
      rvalid_reg <= rvalid_next;
      irq_reg <= irq_next;
      hold_reg <= hold_next;
    end
  end

  // Write engine, address and data have no reset so a write survives reset
  always_ff @(posedge clock) begin
    addr_reg <= addr_next;
    data_reg <= data_next;
    prog_cnt_reg <= prog_cnt_next;
    if (mem_we) begin
      cell_mem[addr_reg] <= data_reg; // R17
    end
  end

  // Strobe register holds across reset so an active write completes;
  // an idle or unknown strobe is cleared by reset at the next edge
  always_ff @(posedge clock) begin
    case (wr_reg)
      1'b1: begin
        wr_reg <= wr_next; // R17
      end
      default: begin
        wr_reg <= rst_n ? wr_next : 1'b0;
      end
    endcase
  end
endmodule : nv_access_ctrl

// file: bench/nv_access_monitor.sv
// Checker for the register link between the core end and the storage end.
// Assumes the bench instantiates it beside the interface, one clock domain.
module nv_access_monitor
  import nv_access_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst_n, // Active-low reset
  input wire io_op_e op, // Operation this cycle
  input wire logic [5:0] addr, // I/O offset
  input wire logic [2:0] bit_sel, // Bit for bit operations
  input wire logic [7:0] wdata, // Write data
  input wire logic [7:0] rdata, // Read data
  input wire logic rvalid, // Answer valid
  input wire logic stall, // Core hold
  input wire logic ready_irq, // Ready interrupt
  input wire logic global_irq_en // Core interrupt enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic [2:0] arm_left_reg; // Clocks left in the arm window
  logic [2:0] arm_left_next; // Next window count
  logic arm_hit; // Operation sets the arm bit
  logic wr_hit; // Operation sets write_strobe
  logic rd_hit; // Operation sets read_strobe
  // Decode strobes and step the arm window
  always_comb begin
    arm_hit = addr == CTRL_ADDR && ((op == OP_WRITE && wdata[ARM_BIT]) || (op == OP_SETBIT && bit_sel == 3'h2));
    wr_hit = addr == CTRL_ADDR && ((op == OP_WRITE && wdata[1]) || (op == OP_SETBIT && bit_sel == 3'h1));
    rd_hit = addr == CTRL_ADDR && ((op == OP_WRITE && wdata[0]) || (op == OP_SETBIT && bit_sel == 3'h0));
    arm_left_next = arm_hit ? ARM_CNT_LOAD : (arm_left_reg != 3'h0 ? arm_left_reg - 3'h1 : 3'h0);
  end
  // Register the window count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arm_left_reg <= 3'h0;
    end else begin
      arm_left_reg <= arm_left_next;
    end
  end
  a_ctrl_high_zero: assert property (op == OP_READ && addr == CTRL_ADDR |=> rvalid && rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_addr_top_zero: assert property (op == OP_READ && addr == ADDR_ADDR |=> rdata[7] == 1'b0)
    else $error("address top bit not zero");
  a_read_answer: assert property (op == OP_READ |=> rvalid)
    else $error("read gave no answer");
  a_bit_test_answer: assert property (op == OP_TESTBIT && addr <= BIT_IO_TOP |=> rvalid)
    else $error("bit test gave no answer");
  a_irq_needs_global: assert property (ready_irq |-> $past(global_irq_en))
    else $error("ready interrupt without global enable");
  a_wr_stall_two: assert property (wr_hit && arm_left_reg != 3'h0 |=> ##[0:1] $rose(stall) ##0 stall [*2] ##1 !stall)
    else $error("write stall not two cycles");
  a_rd_stall_four: assert property (rd_hit |=> ##[0:1] $rose(stall) ##0 stall [*4] ##1 !stall)
    else $error("read stall not four cycles");
  a_strobe_ignored: assert property (wr_hit && !arm_hit && arm_left_reg == 3'h0 |=> !stall [*3])
    else $error("unarmed strobe stalled");
  a_arm_expires: assert property (op == OP_READ && addr == CTRL_ADDR && arm_left_reg == 3'h0 |=> !rdata[ARM_BIT])
    else $error("arm bit outlived its window");
endmodule : nv_access_monitor

// file: bench/eeprom_access_control_test.sv
// Bench for the core end and storage end joined by the register link.
// Assumes a shortened programming period; drives the user sides only.
`define CHK(name, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("[ERR] %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module eeprom_access_control_test import nv_access_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PROG = 40; // Shortened programming period
  logic clock = 1'b0, rst_n = 1'b0, req = 1'b0, irq_en = 1'b0, sleep_req = 1'b0;
  logic [2:0] req_op = 3'h0, req_bit = 3'h0; // Request code and bit
  logic [5:0] req_addr = 6'h00; // Request offset
  logic [7:0] req_data = 8'h00, resp_data, rd_v; // Data out, in, captured
  logic req_done, resp_bit, irq_seen, write_busy, osc_hold, rb_v; // Observed
  int n_errors = 0, samples_checked = 0; // Tallies
  always #5 clock = ~clock;
  nv_io_if bus_if (.clock(clock), .rst_n(rst_n));
  nv_core_port nv_core_port_i (.clock(clock), .rst_n(rst_n), .bus(bus_if), .req(req), .req_op(req_op),
    .req_addr(req_addr), .req_bit(req_bit), .req_data(req_data), .irq_en(irq_en), .req_done(req_done),
    .resp_data(resp_data), .resp_bit(resp_bit), .irq_seen(irq_seen));
  nv_access_ctrl #(.PROG_CYCLES(PROG)) nv_access_ctrl_i (.clock(clock), .rst_n(rst_n), .bus(bus_if),
    .sleep_req(sleep_req), .write_busy(write_busy), .osc_hold(osc_hold));
  nv_access_monitor nv_access_monitor_i (.clock(clock), .rst_n(rst_n), .op(bus_if.op), .addr(bus_if.addr),
    .bit_sel(bus_if.bit_sel), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid),
    .stall(bus_if.stall), .ready_irq(bus_if.ready_irq), .global_irq_en(bus_if.global_irq_en));
  // One request held until completion; keep leaves req up for a follow-on
  task automatic do_op(input logic [2:0] o, input logic [5:0] a, input logic [2:0] b, input logic [7:0] d,
      input bit keep);
    int n;
    n = 0;
    req_op <= o;
    req_addr <= a;
    req_bit <= b;
    req_data <= d;
    req <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (req_done !== 1'b1 && n < 40);
    `CHK("req_done", 1'b1, req_done)
    rd_v = resp_data;
    rb_v = resp_bit;
    if (!keep) begin
      req <= 1'b0;
      @(posedge clock);
    end
  endtask : do_op
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    do_op(OP_WRITE, a, 3'h0, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    do_op(OP_READ, a, 3'h0, 8'h00, 1'b0);
  endtask : rd
  task automatic bit_op(input logic [2:0] o, input int b, input bit keep);
    do_op(o, CTRL_ADDR, 3'(b), 8'h00, keep);
  endtask : bit_op
  // Bounded wait for the self-timed write to finish
  task automatic wait_idle;
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < 2 * PROG + 20) begin
      @(posedge clock);
      n++;
    end
    `CHK("write done", 1'b0, write_busy)
    `CHK("write long", 1'b1, n > PROG / 2)
  endtask : wait_idle
  // Load address and data, arm, then strobe right after
  task automatic arm_write(input logic [6:0] a, input logic [7:0] d);
    wr(ADDR_ADDR, {1'b0, a});
    wr(DATA_ADDR, d);
    bit_op(OP_SETBIT, ARM_BIT, 1'b1);
    bit_op(OP_SETBIT, WR_STROBE_BIT, 1'b0);
    `CHK("write started", 1'b1, write_busy)
  endtask : arm_write
  task automatic read_back(input logic [6:0] a, input logic [7:0] d);
    wr(ADDR_ADDR, {1'b0, a});
    bit_op(OP_SETBIT, RD_STROBE_BIT, 1'b0);
    rd(DATA_ADDR);
    `CHK("read data", d, rd_v)
  endtask : read_back
  task automatic t_ctrl_bits;
    rd(CTRL_ADDR);
    `CHK("ctrl reset", CTRL_RESET, rd_v)
    wr(CTRL_ADDR, 8'hF8);
    rd(CTRL_ADDR);
    `CHK("ctrl reserved", 8'h08, rd_v)
    irq_en <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK("irq on", 1'b1, irq_seen)
    irq_en <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK("irq masked", 1'b0, irq_seen)
    irq_en <= 1'b1;
    wr(ADDR_ADDR, 8'hFF);
    rd(ADDR_ADDR);
    `CHK("addr top", 8'h7F, rd_v)
  endtask : t_ctrl_bits
  task automatic t_write_read;
    arm_write(7'h05, 8'hA5);
    repeat (3) @(posedge clock);
    `CHK("irq busy", 1'b0, irq_seen)
    rd(CTRL_ADDR);
    `CHK("strobe set", 1'b1, rd_v[WR_STROBE_BIT])
    wait_idle();
    repeat (3) @(posedge clock);
    `CHK("irq ready", 1'b1, irq_seen)
    read_back(7'h05, 8'hA5);
    rd(CTRL_ADDR);
    `CHK("read strobe clear", 1'b0, rd_v[RD_STROBE_BIT])
  endtask : t_write_read
  task automatic t_no_arm;
    bit_op(OP_SETBIT, WR_STROBE_BIT, 1'b0);
    `CHK("no arm", 1'b0, write_busy)
    rd(CTRL_ADDR);
    `CHK("strobe low", 1'b0, rd_v[WR_STROBE_BIT])
    bit_op(OP_SETBIT, ARM_BIT, 1'b0);
    repeat (ARM_CYCLES) @(posedge clock);
    bit_op(OP_SETBIT, WR_STROBE_BIT, 1'b0);
    `CHK("arm expired", 1'b0, write_busy)
  endtask : t_no_arm
  task automatic t_bit_ops;
    bit_op(OP_TESTBIT, IRQ_EN_BIT, 1'b0);
    `CHK("test set", 1'b1, rb_v)
    bit_op(OP_CLRBIT, IRQ_EN_BIT, 1'b0);
    bit_op(OP_TESTBIT, IRQ_EN_BIT, 1'b0);
    `CHK("test clear", 1'b0, rb_v)
    rd(CTRL_ADDR);
    `CHK("clear bit", 8'h00, rd_v)
  endtask : t_bit_ops
  task automatic t_abort;
    arm_write(7'h05, 8'h5A);
    wr(DATA_ADDR, 8'h11);
    repeat (2) @(posedge clock);
    `CHK("aborted", 1'b0, write_busy)
    read_back(7'h05, 8'hA5);
  endtask : t_abort
  task automatic t_sleep_reset;
    irq_en <= 1'b0;
    arm_write(7'h06, 8'h3C);
    sleep_req <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK("osc held", 1'b1, osc_hold)
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK("write survives", 1'b1, write_busy)
    rst_n <= 1'b1;
    wait_idle();
    repeat (2) @(posedge clock);
    `CHK("osc released", 1'b0, osc_hold)
    sleep_req <= 1'b0;
    read_back(7'h06, 8'h3C);
  endtask : t_sleep_reset
  // Print the verdict and end the run
  task automatic report_and_stop;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence after an eight-cycle reset
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_ctrl_bits();
    t_write_read();
    t_no_arm();
    t_bit_ops();
    t_abort();
    t_sleep_reset();
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    repeat (4000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
endmodule : eeprom_access_control_test
